// ==== rtl/mbsr_pkg.sv ====
// constants for the multiplexed thumbwheel switch reader
// assumes a 250 MHz clock and a 3-bit word-indexed register port
package mbsr_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int NS_PER_MS = 1000000;
    localparam int CYCLES_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
    localparam logic [15:0] DWELL_MS_RESET = 16'h0014;       // 20 ms after initialisation
    localparam logic [15:0] DWELL_MS_REAL_SWITCH = 16'h0007; // suggested for real switches

    // ****************************************
    // register indexes
    // ****************************************
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_HEAD = 3'h1;
    localparam logic [2:0] REG_DWELL = 3'h2;
    localparam logic [2:0] REG_STATUS = 3'h3;
    localparam logic [2:0] REG_RESULT_LO = 3'h4;
    localparam logic [2:0] REG_RESULT_HI = 3'h5;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CTRL_CODE_LSB = 0;    // 5-bit digit-count code
    localparam int CTRL_DOUBLE_BIT = 8;  // 1: double-word width
    localparam int CTRL_START_BIT = 9;   // write one to start a scan
    localparam int HEAD_IN_LSB = 0;      // 4-bit head input index
    localparam int HEAD_OUT_LSB = 8;     // 4-bit head output index
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_BADDIGIT_BIT = 2;
    localparam int STAT_BADCFG_BIT = 3;
    localparam int STAT_INDEX_LSB = 4;

    // ****************************************
    // digit-count codes
    // ****************************************
    localparam logic [4:0] CODE_SIGNED_OFFSET = 5'h10;
    localparam logic [3:0] DIGITS_MAX = 4'h8;
    localparam logic [3:0] DIGITS_SINGLE_MAX = 4'h4;
    localparam logic [3:0] DIGITS_REDUCED_MAX = 4'h6;
    localparam logic [3:0] BCD_MAX = 4'h9;

    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b00,
        SCAN_DWELL = 2'b01,
        SCAN_SAMPLE = 2'b10,
        SCAN_STORE = 2'b11
    } mbsr_state_e;

endpackage

// ==== rtl/mbsr_pin_sync.sv ====
// three-stage synchroniser for the switch input pins
// assumes pins are asynchronous to clk; a bit changes once stages two and three agree
`timescale 1ns/100ps
module mbsr_pin_sync #(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinClean
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_pinClean;

    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_pinClean[i] = (stage2[i] == stage3[i]) ? stage3[i] : pinClean[i];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            pinClean <= '0;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
            pinClean <= next_pinClean;
        end
    end

endmodule

// ==== rtl/mbsr_dwell_timer.sv ====
// digit dwell timer counted in milliseconds
// assumes run stays high for the whole dwell; dropping run clears the count
`timescale 1ns/100ps
module mbsr_dwell_timer #(
    parameter int CYC_PER_MS = 250000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [15:0] dwellMs,
    output logic expired
);

    logic [31:0] preCnt;
    logic [15:0] msCnt;
    logic [31:0] next_preCnt;
    logic [15:0] next_msCnt;
    logic next_expired;
    logic [15:0] target;

    always_comb begin
        // a zero setting would never wait, so it is held to one millisecond
        target = (dwellMs == 16'h0000) ? 16'h0001 : dwellMs;
        next_preCnt = preCnt;
        next_msCnt = msCnt;
        next_expired = 1'b0;
        if (!run) begin
            next_preCnt = '0;
            next_msCnt = '0;
        end else if (msCnt >= target) begin
            next_expired = 1'b1;
        end else if (preCnt == 32'(CYC_PER_MS - 1)) begin
            next_preCnt = '0;
            next_msCnt = msCnt + 16'h0001;
        end else begin
            next_preCnt = preCnt + 32'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            preCnt <= '0;
            msCnt <= '0;
            expired <= 1'b0;
        end else begin
            preCnt <= next_preCnt;
            msCnt <= next_msCnt;
            expired <= next_expired;
        end
    end

endmodule

// ==== rtl/mbsr_switch_scan_read.sv ====
// switch_scan_read: time-shared reader for a bank of decimal thumbwheel switches
// assumes a register master on clk with one-cycle strobes and switch pins async to clk
// What this block does
// - unsigned: four BCD lines from head input
// - one to eight selects from head output
// - single width: four digits into one word
// - double width: eight digits into two words
// - codes 1-4 single only, 5-8 double only
// - one select output per configured digit
// - codes 17-24 mean signed, digits plus sixteen
// - signed: sign line then four BCD lines
// - sign active means negative stored value
// - five to eight digits need double width
// - each select dwells programmable time, default 20ms
// - about 7ms suits real switches
// - reduced variant: six unsigned digits, no signed
`timescale 1ns/100ps
module mbsr_switch_scan_read
    import mbsr_pkg::*;
#(
    parameter int IN_W = 16,
    parameter int OUT_W = 16,
    parameter int CYC_PER_MS = CYCLES_PER_MS,
    parameter bit REDUCED = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdData,
    input wire logic [IN_W-1:0] switchPins,
    output logic [OUT_W-1:0] digitSelect
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] times10(input logic [31:0] w);
        times10 = (w << 3) + (w << 1);
    endfunction

    function automatic logic [31:0] digitTimes(input logic [3:0] d, input logic [31:0] w);
        digitTimes = (d[0] ? w : 32'h0) + (d[1] ? (w << 1) : 32'h0)
            + (d[2] ? (w << 2) : 32'h0) + (d[3] ? (w << 3) : 32'h0);
    endfunction

    // ****************************************
    // state
    // ****************************************
    mbsr_state_e state;
    mbsr_state_e next_state;
    logic [4:0] code;
    logic doubleWidth;
    logic [3:0] headIn;
    logic [3:0] headOut;
    logic [15:0] dwellMs;
    logic [15:0] resultLo;
    logic [15:0] resultHi;
    logic done;
    logic badDigit;
    logic badCfg;
    logic [3:0] digitIdx;
    logic [3:0] digitCount;
    logic signedRun;
    logic doubleRun;
    logic [3:0] inBase;
    logic [31:0] acc;
    logic [31:0] weight;
    logic [4:0] next_code;
    logic next_doubleWidth;
    logic [3:0] next_headIn;
    logic [3:0] next_headOut;
    logic [15:0] next_dwellMs;
    logic [15:0] next_resultLo;
    logic [15:0] next_resultHi;
    logic next_done;
    logic next_badDigit;
    logic next_badCfg;
    logic [3:0] next_digitIdx;
    logic [3:0] next_digitCount;
    logic next_signedRun;
    logic next_doubleRun;
    logic [3:0] next_inBase;
    logic [31:0] next_acc;
    logic [31:0] next_weight;
    logic [OUT_W-1:0] next_digitSelect;
    logic [15:0] next_regRdData;

    logic [IN_W-1:0] pinClean;
    logic dwellDone;
    logic startReq;
    logic cfgOk;
    logic cfgSigned;
    logic [3:0] cfgDigits;
    logic [3:0] cfgBase;
    logic [3:0] sampledDigit;
    logic [IN_W-1:0] shiftedPins;
    logic [31:0] signedAcc;
    logic [4:0] wrCode;
    logic wrDouble;

    mbsr_pin_sync #(
        .WIDTH(IN_W)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .pinIn(switchPins),
        .pinClean(pinClean)
    );

    mbsr_dwell_timer #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .run(state == SCAN_DWELL),
        .dwellMs(dwellMs),
        .expired(dwellDone)
    );

    // ****************************************
    // start decode and configuration check
    // ****************************************
    always_comb begin
        startReq = regWr && (regAddr == REG_CTRL) && regWrData[CTRL_START_BIT];
        // a start write checks the code it carries, so one write both sets and launches
        wrCode = regWrData[CTRL_CODE_LSB +: 5];
        wrDouble = regWrData[CTRL_DOUBLE_BIT];
        cfgSigned = wrCode[4];
        cfgDigits = wrCode[3:0];
        cfgBase = cfgSigned ? headIn + 4'h1 : headIn;
        // bit 3 is only legal in the eight-digit codes, unsigned and signed
        cfgOk = (wrCode[3] == 1'b0) || (wrCode[2:0] == 3'h0);
        cfgOk = cfgOk && cfgDigits != 4'h0 && cfgDigits <= DIGITS_MAX;
        if (cfgDigits > DIGITS_SINGLE_MAX && !wrDouble) begin
            cfgOk = 1'b0;
        end
        if (!cfgSigned && cfgDigits <= DIGITS_SINGLE_MAX && wrDouble) begin
            cfgOk = 1'b0;
        end
        if (REDUCED && (cfgSigned || cfgDigits > DIGITS_REDUCED_MAX)) begin
            cfgOk = 1'b0;
        end
        if (32'(headIn) + 32'(cfgSigned) + 32'h4 > 32'(IN_W)
            || 32'(headOut) + 32'(cfgDigits) > 32'(OUT_W)) begin // selected lines must exist
            cfgOk = 1'b0;
        end
    end

    // ****************************************
    // scan sequencer
    // ****************************************
    always_comb begin
        next_state = state;
        next_code = code;
        next_doubleWidth = doubleWidth;
        next_headIn = headIn;
        next_headOut = headOut;
        next_dwellMs = dwellMs;
        next_resultLo = resultLo;
        next_resultHi = resultHi;
        next_done = done;
        next_badDigit = badDigit;
        next_badCfg = badCfg;
        next_digitIdx = digitIdx;
        next_digitCount = digitCount;
        next_signedRun = signedRun;
        next_doubleRun = doubleRun;
        next_inBase = inBase;
        next_acc = acc;
        next_weight = weight;
        next_digitSelect = '0;
        shiftedPins = pinClean >> inBase;
        sampledDigit = shiftedPins[3:0];
        signedAcc = (signedRun && pinClean[headIn]) ? (~acc + 32'h1) : acc;

        // configuration is frozen while a scan runs
        if (regWr && state == SCAN_IDLE) begin
            case (regAddr)
                REG_CTRL: begin
                    next_code = wrCode;
                    next_doubleWidth = wrDouble;
                end
                REG_HEAD: begin
                    next_headIn = regWrData[HEAD_IN_LSB +: 4];
                    next_headOut = regWrData[HEAD_OUT_LSB +: 4];
                end
                REG_DWELL: begin
                    next_dwellMs = regWrData;
                end
                default: begin
                end
            endcase
        end

        case (state)
            SCAN_IDLE: begin
                if (startReq) begin
                    next_done = 1'b0;
                    next_badDigit = 1'b0;
                    next_badCfg = !cfgOk;
                    if (cfgOk) begin
                        next_state = SCAN_DWELL;
                        next_digitIdx = 4'h0;
                        next_digitCount = cfgDigits;
                        next_signedRun = cfgSigned;
                        next_doubleRun = wrDouble;
                        next_inBase = cfgBase;
                        next_acc = '0;
                        next_weight = 32'h1;
                    end
                end
            end
            SCAN_DWELL: begin
                // exactly one select high; the far end must settle inside the dwell
                next_digitSelect = OUT_W'(1) << (headOut + digitIdx);
                if (dwellDone) begin
                    next_state = SCAN_SAMPLE;
                end
            end
            SCAN_SAMPLE: begin
                // select released here so neighbouring digits never overlap
                if (sampledDigit > BCD_MAX) begin
                    next_badDigit = 1'b1;
                    next_done = 1'b1;
                    next_state = SCAN_IDLE;
                end else begin
                    next_acc = acc + digitTimes(sampledDigit, weight);
                    next_weight = times10(weight);
                    if (digitIdx + 4'h1 == digitCount) begin
                        next_state = SCAN_STORE;
                    end else begin
                        next_digitIdx = digitIdx + 4'h1;
                        next_state = SCAN_DWELL;
                    end
                end
            end
            SCAN_STORE: begin
                next_resultLo = signedAcc[15:0];
                if (doubleRun) begin
                    next_resultHi = signedAcc[31:16];
                end
                next_done = 1'b1;
                next_state = SCAN_IDLE;
            end
            default: begin
                next_state = SCAN_IDLE;
            end
        endcase
    end

    // ****************************************
    // read port
    // ****************************************
    always_comb begin
        next_regRdData = 16'h0000;
        if (regRd) begin
            case (regAddr)
                REG_CTRL: begin
                    next_regRdData[CTRL_CODE_LSB +: 5] = code;
                    next_regRdData[CTRL_DOUBLE_BIT] = doubleWidth;
                end
                REG_HEAD: begin
                    next_regRdData[HEAD_IN_LSB +: 4] = headIn;
                    next_regRdData[HEAD_OUT_LSB +: 4] = headOut;
                end
                REG_DWELL: begin
                    next_regRdData = dwellMs;
                end
                REG_STATUS: begin
                    next_regRdData[STAT_BUSY_BIT] = (state != SCAN_IDLE);
                    next_regRdData[STAT_DONE_BIT] = done;
                    next_regRdData[STAT_BADDIGIT_BIT] = badDigit;
                    next_regRdData[STAT_BADCFG_BIT] = badCfg;
                    next_regRdData[STAT_INDEX_LSB +: 4] = digitIdx;
                end
                REG_RESULT_LO: begin
                    next_regRdData = resultLo;
                end
                REG_RESULT_HI: begin
                    next_regRdData = resultHi;
                end
                default: begin
                    next_regRdData = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= SCAN_IDLE;
            code <= 5'h04;
            doubleWidth <= 1'b0;
            headIn <= 4'h0;
            headOut <= 4'h0;
            dwellMs <= DWELL_MS_RESET;
            resultLo <= 16'h0000;
            resultHi <= 16'h0000;
            done <= 1'b0;
            badDigit <= 1'b0;
            badCfg <= 1'b0;
            digitIdx <= 4'h0;
            digitCount <= 4'h0;
            signedRun <= 1'b0;
            doubleRun <= 1'b0;
            inBase <= 4'h0;
            acc <= 32'h0;
            weight <= 32'h1;
            digitSelect <= '0;
            regRdData <= 16'h0000;
        end else begin
            state <= next_state;
            code <= next_code;
            doubleWidth <= next_doubleWidth;
            headIn <= next_headIn;
            headOut <= next_headOut;
            dwellMs <= next_dwellMs;
            resultLo <= next_resultLo;
            resultHi <= next_resultHi;
            done <= next_done;
            badDigit <= next_badDigit;
            badCfg <= next_badCfg;
            digitIdx <= next_digitIdx;
            digitCount <= next_digitCount;
            signedRun <= next_signedRun;
            doubleRun <= next_doubleRun;
            inBase <= next_inBase;
            acc <= next_acc;
            weight <= next_weight;
            digitSelect <= next_digitSelect;
            regRdData <= next_regRdData;
        end
    end

endmodule

// ==== sim/mbsr_switch_scan_read_asserts.sv ====
// port assertions for the thumbwheel switch reader
// assumes a bind into mbsr_switch_scan_read; sees only its ports
`timescale 1ns/100ps
module mbsr_switch_scan_read_asserts
    import mbsr_pkg::*;
#(
    parameter int IN_W = 16,
    parameter int OUT_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [15:0] regRdData,
    input wire logic [IN_W-1:0] switchPins,
    input wire logic [OUT_W-1:0] digitSelect
);
    // ****************************
    // scan tracking
    // ****************************
    logic [3:0] hOut, next_hOut, maxDig, next_maxDig, selCnt, next_selCnt;
    logic [3:0] hIn, next_hIn, nib, next_nib;
    logic sgnCfg, next_sgnCfg;
    logic [OUT_W-1:0] lastSel, next_lastSel;
    logic selAny, prevAny;

    // illegal configs give zero, so any select after them trips the count check
    function automatic logic [3:0] legalDigits(input logic [4:0] c, input logic d);
        if (c[3:0] == 4'h0 || c[3:0] > 4'h8) begin
            return 4'h0;
        end
        if (c[4]) begin
            return (c[3:0] > 4'h4 && !d) ? 4'h0 : c[3:0];
        end
        return ((c[3:0] > 4'h4) == d) ? c[3:0] : 4'h0;
    endfunction

    assign selAny = digitSelect != '0;

    always_comb begin
        next_hOut = hOut;
        next_maxDig = maxDig;
        next_selCnt = selCnt;
        next_lastSel = selAny ? digitSelect : lastSel;
        next_hIn = hIn;
        next_sgnCfg = sgnCfg;
        // digit shown on the BCD lines while a select is high; a bad one aborts the scan
        next_nib = selAny ? 4'(switchPins >> (hIn + 4'(sgnCfg))) : nib;
        if (regWr && regAddr == REG_HEAD) begin
            next_hOut = regWrData[11:8];
            next_hIn = regWrData[3:0];
        end
        if (regWr && regAddr == REG_CTRL && regWrData[CTRL_START_BIT]) begin
            next_sgnCfg = regWrData[4];
            next_maxDig = legalDigits(regWrData[4:0], regWrData[CTRL_DOUBLE_BIT]);
            next_selCnt = 4'h0;
        end else if (selAny && !prevAny) begin
            next_selCnt = selCnt + 4'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hOut <= 4'h0;
            maxDig <= 4'h0;
            selCnt <= 4'h0;
            lastSel <= '0;
            prevAny <= 1'b0;
            hIn <= 4'h0;
            nib <= 4'h0;
            sgnCfg <= 1'b0;
        end else begin
            hOut <= next_hOut;
            maxDig <= next_maxDig;
            selCnt <= next_selCnt;
            lastSel <= next_lastSel;
            prevAny <= selAny;
            hIn <= next_hIn;
            nib <= next_nib;
            sgnCfg <= next_sgnCfg;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_selRise;
        $rose(selAny);
    endsequence

    a_one_select: assert property ($onehot0(digitSelect))
        else $error("more than one digit select high");
    a_first_head: assert property (s_selRise ##0 selCnt == 4'h0 |->
        digitSelect == (OUT_W'(1) << hOut)) else $error("first select not at head");
    a_sel_step: assert property (s_selRise ##0 selCnt != 4'h0 |->
        digitSelect == (lastSel << 1)) else $error("select did not step up one");
    a_sel_count: assert property (selCnt <= maxDig)
        else $error("more selects than configured digits");
    a_sel_hold: assert property (s_selRise |=> $stable(digitSelect) [*8])
        else $error("select dropped before dwell");
    a_sel_gap: assert property ($fell(selAny) && selCnt < maxDig && nib <= BCD_MAX
        |-> ##[1:4] selAny) else $error("next digit select late");
    a_rd_quiet: assert property (regRdData != 16'h0000 |-> $past(regRd))
        else $error("read data outside read slot");
    a_dwell_back: assert property (regWr && regAddr == REG_DWELL && regWrData != 16'h0000
        ##2 regRd && regAddr == REG_DWELL |=> regRdData == $past(regWrData, 3))
        else $error("dwell readback wrong");
endmodule

// ==== sim/mbsr_switch_bank.sv ====
// model of a bank of multiplexed thumbwheel switches plus a sign switch
// assumes active-high selects, one at a time; answers a set number of cycles late
`timescale 1ns/100ps
module mbsr_switch_bank (
    input wire logic clk,
    input wire logic [15:0] digitSelect,
    input wire logic [3:0] headIn,
    input wire logic [3:0] headOut,
    input wire logic signedMode,
    input wire logic signNeg,
    input wire logic [31:0] digitWord,
    input wire logic [3:0] delay,
    output logic [15:0] switchPins
);
    logic [15:0] prevSel = 16'h0000;
    logic [15:0] pins;
    logic [3:0] lastBcd = 4'h0;
    logic [3:0] bcd;
    int held = 0;

    always @(posedge clk) begin
        held = (digitSelect != 16'h0000 && digitSelect == prevSel) ? held + 1 : 0;
        // undriven lines float: never let the old code linger
        bcd = ~lastBcd;
        if (digitSelect != 16'h0000 && held >= delay) begin
            for (int i = 0; i < 8; i++) begin
                if (digitSelect[headOut + i]) begin
                    bcd = digitWord[4 * i +: 4];
                end
            end
            lastBcd = bcd;
        end
        pins = 16'h0000;
        pins[headIn + signedMode +: 4] = bcd;
        pins[headIn] = signedMode ? signNeg : pins[headIn];
        switchPins <= pins;
        prevSel = digitSelect;
    end
endmodule

// ==== sim/mbsr_switch_scan_read_tb_top.sv ====
// self-checking bench for the thumbwheel switch reader
// assumes CYC_PER_MS shrunk to 10 so a millisecond is ten clocks
`timescale 1ns/100ps
module mbsr_switch_scan_read_tb_top;
    import mbsr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] regAddr = 3'h0;
    logic [15:0] regWrData = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] regRdData, switchPins, digitSelect;
    logic [3:0] headIn = 4'h0;
    logic [3:0] headOut = 4'h0;
    logic [3:0] delay = 4'h0;
    logic signedMode = 1'b0;
    logic signNeg = 1'b0;
    logic [31:0] digitWord = 32'h0;
    int errTotal = 0;
    int checksDone = 0;
    int run = 0;
    int lastRun = 0;

    initial begin
        forever #2 clk = ~clk;
    end

    mbsr_switch_scan_read #(.CYC_PER_MS(10)) dut_u (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .switchPins(switchPins), .digitSelect(digitSelect));
    mbsr_switch_bank bank_u (.clk(clk), .digitSelect(digitSelect), .headIn(headIn),
        .headOut(headOut), .signedMode(signedMode), .signNeg(signNeg),
        .digitWord(digitWord), .delay(delay), .switchPins(switchPins));

    // length of the most recent select pulse
    always @(posedge clk) begin
        if (digitSelect != 16'h0000) begin
            run++;
        end else if (run != 0) begin
            lastRun = run;
            run = 0;
        end
    end

    // ****************************
    // bus and check helpers
    // ****************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            errTotal++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask

    function automatic logic [31:0] expv(input logic [31:0] w, input int n, input logic neg);
        logic [31:0] v;
        v = 32'h0;
        for (int i = n - 1; i >= 0; i--) begin
            v = v * 32'hA + w[4 * i +: 4];
        end
        return neg ? -v : v;
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic scan(input logic [4:0] code, input logic dbl, input logic [15:0] ms,
            output logic [15:0] st, output logic [31:0] res);
        int n;
        st = 16'h0000;
        n = 0;
        signedMode = code[4];
        wr(REG_HEAD, {4'h0, headOut, 4'h0, headIn});
        wr(REG_DWELL, ms);
        wr(REG_CTRL, {6'h00, 1'b1, dbl, 3'h0, code});
        while ((st & 16'h000A) == 16'h0000 && n < 3000) begin
            rd(REG_STATUS, st);
            n++;
        end
        if (n >= 3000) begin
            errTotal++;
            end_of_test();
        end
        rd(REG_RESULT_LO, res[15:0]);
        rd(REG_RESULT_HI, res[31:16]);
    endtask

    // ****************************
    // scenarios
    // ****************************
    task automatic t_reset();
        logic [15:0] d;
        rd(REG_DWELL, d);
        chk("dwell reset", 32'h14, d);
        rd(REG_STATUS, d);
        chk("status reset", 32'h0, d);
        chk("select idle", 32'h0, digitSelect);
        wr(3'h6, 16'hFFFF);
        rd(3'h6, d);
        chk("unmapped", 32'h0, d);
        wr(REG_DWELL, 16'h0003);
        rd(REG_DWELL, d);
        chk("dwell rw", 32'h3, d);
        $display("test reset done");
    endtask

    task automatic t_read(input logic sgn);
        logic [15:0] st;
        logic [31:0] res, e;
        headIn = sgn ? 4'h0 : 4'h2;
        headOut = sgn ? 4'h8 : 4'h3;
        digitWord = sgn ? 32'h19283746 : 32'h87654321;
        for (int n = 1; n <= 8; n++) begin
            delay = n[0] ? 4'h5 : 4'h0;
            signNeg = sgn & n[0];
            scan({sgn, n[3:0]}, n > 4, 16'h0001, st, res);
            e = expv(digitWord, n, signNeg);
            chk("scan status", 32'h2, st & 16'h000F);
            chk("result low", e[15:0], res[15:0]);
            if (n > 4) begin
                chk("result high", e[31:16], res[31:16]);
            end
        end
        $display("test read signed=%0d done", sgn);
    endtask

    task automatic t_faults();
        logic [5:0] cfg [5] = '{6'h05, 6'h24, 6'h15, 6'h29, 6'h00};
        logic [15:0] st, prev;
        logic [31:0] res;
        // last value stored by the signed pass: eight positive digits
        res = expv(32'h19283746, 8, 1'b0);
        prev = res[15:0];
        for (int i = 0; i < 5; i++) begin
            scan(cfg[i][4:0], cfg[i][5], 16'h0001, st, res);
            chk("bad config flag", 32'h8, st & 16'h0008);
            chk("config keeps result", prev, res[15:0]);
        end
        headIn = 4'h2;
        headOut = 4'h0;
        digitWord = 32'h000002A1;
        scan(5'h03, 1'b0, 16'h0001, st, res);
        chk("bad digit flags", 32'h6, st & 16'h000F);
        chk("bad digit keeps result", prev, res[15:0]);
        $display("test faults done");
    endtask

    task automatic t_dwell();
        logic [15:0] st;
        logic [31:0] res;
        digitWord = 32'h00000095;
        delay = 4'h3;
        scan(5'h02, 1'b0, 16'h0007, st, res);
        chk("dwell cycles", 32'h1, lastRun >= 70 && lastRun <= 74);
        chk("dwell result", 32'h5F, res[15:0]);
        $display("test dwell done");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_read(1'b0);
        t_read(1'b1);
        t_faults();
        t_dwell();
        end_of_test();
    end
endmodule

bind mbsr_switch_scan_read mbsr_switch_scan_read_asserts #(.IN_W(IN_W), .OUT_W(OUT_W)) chk_u (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .switchPins(switchPins), .digitSelect(digitSelect));
